// ===== inc/sdpp_pkg.sv
// constants shared by the device end and the host end of the divider program port
// assumes one 25 MHz clock on both ends
package sdpp_pkg;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int          FRAME_W = 14;
    localparam int          T_MSB   = 13;
    localparam int          T_LSB   = 11;
    localparam int          N_MSB   = 10;
    localparam int          N_LSB   = 9;
    localparam int          M_MSB   = 8;
    localparam logic [3:0]  LAST_BIT_IDX = 4'hd;

    // ----------------------------------------------------------------
    // pin bus positions inside the device synchroniser
    // ----------------------------------------------------------------
    localparam int PIN_W     = 15;
    localparam int PIN_PLOAD = 14;
    localparam int PIN_SLOAD = 13;
    localparam int PIN_SCLK  = 12;
    localparam int PIN_SDATA = 11;
    localparam int PIN_N_LSB = 9;

    // ----------------------------------------------------------------
    // codes and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] POST_DIV2  = 2'h0;
    localparam logic [1:0] POST_DIV4  = 2'h1;
    localparam logic [1:0] POST_DIV8  = 2'h2;
    localparam logic [1:0] POST_DIV1  = 2'h3;
    localparam logic [2:0] TEST_SHIFT = 3'h0;
    localparam logic [2:0] TEST_ONE   = 3'h1;
    localparam logic [2:0] TEST_REF16 = 3'h2;
    localparam logic [2:0] TEST_MCNT  = 3'h3;
    localparam logic [2:0] TEST_PAIR  = 3'h4;
    localparam logic [2:0] TEST_ZERO  = 3'h5;
    localparam logic [2:0] TEST_BYP   = 3'h6;
    localparam logic [2:0] TEST_PAIR4 = 3'h7;
    localparam logic [2:0] TEST_QUIET = 3'h0;
    localparam logic [8:0] FB_RST     = 9'h100;
    localparam logic [1:0] POST_RST   = 2'h0;
    localparam logic [6:0] REF_PRE    = 7'h08;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_NS        = 40;
    localparam int T_PULSE_NS    = 50;
    localparam int T_SCLK_MIN_NS = 100;
    localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HALF_CYC  = 4'((T_SCLK_MIN_NS / 2 + CLK_NS - 1) / CLK_NS);

    // ----------------------------------------------------------------
    // host register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W     = 4;
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_PAR    = 2'h1;
    localparam logic [1:0] REG_SER    = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
    localparam int CTRL_PLOAD = 0;
    localparam int CTRL_START = 1;
    localparam int PAR_N_LSB  = 9;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [6:0] sdpp_ratio(input logic [1:0] code);
        unique case (code)
            POST_DIV2: sdpp_ratio = 7'h02;
            POST_DIV4: sdpp_ratio = 7'h04;
            POST_DIV8: sdpp_ratio = 7'h08;
            POST_DIV1: sdpp_ratio = 7'h01;
        endcase
    endfunction : sdpp_ratio

endpackage : sdpp_pkg

// ===== inc/sdpp_if.sv
// configuration pins between the host end and the synthesizer end
// assumes both ends run on the same aclk
`timescale 1ns/100ps
`default_nettype none
interface sdpp_if;
    logic       p_load;
    logic       s_load;
    logic       s_clock;
    logic       s_data;
    logic [8:0] m_in;
    logic [1:0] n_in;
    logic       synth_output_pair_p;
    logic       synth_output_pair_n;
    logic       test_out;

    modport device (
        input  p_load, s_load, s_clock, s_data, m_in, n_in,
        output synth_output_pair_p, synth_output_pair_n, test_out
    );
    modport host (
        output p_load, s_load, s_clock, s_data, m_in, n_in,
        input  synth_output_pair_p, synth_output_pair_n, test_out
    );
endinterface : sdpp_if
`default_nettype wire

// ===== hdl/sdpp_device.sv
// synthesizer end: divider configuration logic and a digital stand-in for the clock path
// assumes pins arrive asynchronously; vco is modelled as aclk / 2
//
// Notes on behaviour
// - post select 00/01/10/11 divides 2/4/8/1
// - step equals reference over 8 over ratio
// - parallel strobe rise captures m and n
// - strobe low: parallel inputs pass straight through
// - serial clock shifts data into 14 bits
// - serial load works only with strobe high
// - frame order: test, post, then feedback
// - each field sent most significant bit first
// - serial load fall transfers shifted values
// - host sets parallel first, serial later
// - strobe low forces test select 000
// - test code 110 bypasses pll via sclk
`timescale 1ns/100ps
`default_nettype none
module sdpp_device
    import sdpp_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    sdpp_if.device          pins,
    output logic [8:0]      fb_count,
    output logic [1:0]      post_sel,
    output logic [2:0]      test_sel,
    output logic [6:0]      step_divisor,
    output logic            bypass
);
    import sdpp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchroniser
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_d;

    assign pin_raw = {pins.p_load, pins.s_load, pins.s_clock, pins.s_data,
                      pins.n_in, pins.m_in};

    // m and n skew across bits is settled by the 20 ns setup before the strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_d  <= '0;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_d  <= pin_s2;
        end
    end

    logic       p_load;
    logic       p_rise;
    logic       sclk_rise;
    logic       sload_fall;
    logic       s_data;
    logic [8:0] m_pin;
    logic [1:0] n_pin;

    assign p_load     = pin_s2[PIN_PLOAD];
    assign p_rise     = pin_s2[PIN_PLOAD] & ~pin_d[PIN_PLOAD];
    assign sclk_rise  = pin_s2[PIN_SCLK] & ~pin_d[PIN_SCLK];
    assign sload_fall = ~pin_s2[PIN_SLOAD] & pin_d[PIN_SLOAD];
    assign s_data     = pin_s2[PIN_SDATA];
    assign m_pin      = pin_s2[M_MSB:0];
    assign n_pin      = pin_s2[PIN_N_LSB+1:PIN_N_LSB];

    // ----------------------------------------------------------------
    // serial shift register
    // ----------------------------------------------------------------
    logic [FRAME_W-1:0] shreg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shreg <= '0;
        end else if (sclk_rise && p_load) begin
            shreg <= {shreg[FRAME_W-2:0], s_data};
        end
    end

    // ----------------------------------------------------------------
    // divider configuration
    // ----------------------------------------------------------------
    // parallel path wins; serial transfer is ignored while the strobe is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fb_count <= FB_RST;
            post_sel <= POST_RST;
            test_sel <= TEST_QUIET;
        end else if (!p_load) begin
            fb_count <= m_pin;
            post_sel <= n_pin;
            test_sel <= TEST_QUIET;
        end else if (p_rise) begin
            fb_count <= m_pin;
            post_sel <= n_pin;
        end else if (sload_fall) begin
            test_sel <= shreg[T_MSB:T_LSB];
            post_sel <= shreg[N_MSB:N_LSB];
            fb_count <= shreg[M_MSB:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_divisor <= REF_PRE * sdpp_ratio(POST_RST);
        end else begin
            step_divisor <= 7'(REF_PRE * sdpp_ratio(post_sel));
        end
    end

    // ----------------------------------------------------------------
    // clock path stand-in
    // ----------------------------------------------------------------
    logic vco;
    logic src_level;
    logic src_prev;
    logic src_rise;

    assign bypass    = (test_sel == TEST_BYP);
    assign src_level = bypass ? pin_s2[PIN_SCLK] : vco;
    assign src_rise  = src_level & ~src_prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vco      <= 1'b0;
            src_prev <= 1'b0;
        end else begin
            vco      <= ~vco;
            src_prev <= src_level;
        end
    end

    // post divider: one binary counter serves ratios 2, 4 and 8; ratio 1 passes the source straight through
    logic [2:0] post_cnt;
    logic       post_out;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            post_cnt <= '0;
        end else if (src_rise) begin
            post_cnt <= post_cnt + 3'h1;
        end
    end

    always_comb begin
        unique case (post_sel)
            POST_DIV2: post_out = post_cnt[0];
            POST_DIV4: post_out = post_cnt[1];
            POST_DIV8: post_out = post_cnt[2];
            POST_DIV1: post_out = src_level;
        endcase
    end

    // feedback counter; m_out toggles every fb_count source rises (at least one), so duty is 50 % for odd counts too
    logic [8:0] fb_cnt;
    logic       m_out;
    logic       fb_wrap;

    assign fb_wrap = ({1'b0, fb_cnt} + 10'h001) >= {1'b0, fb_count};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fb_cnt <= '0;
            m_out  <= 1'b0;
        end else if (src_rise) begin
            if (fb_wrap) begin
                fb_cnt <= '0;
                m_out  <= ~m_out;
            end else begin
                fb_cnt <= fb_cnt + 9'h001;
            end
        end
    end

    // reference / 16 and output / 4 for the test selector
    logic [3:0] ref_cnt;
    logic       post_prev;
    logic [1:0] pair_cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_cnt   <= '0;
            post_prev <= 1'b0;
            pair_cnt  <= '0;
        end else begin
            ref_cnt   <= ref_cnt + 4'h1;
            post_prev <= post_out;
            if (post_out && !post_prev) begin
                pair_cnt <= pair_cnt + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic next_test;

    always_comb begin
        unique case (test_sel)
            TEST_SHIFT: next_test = shreg[FRAME_W-1];
            TEST_ONE:   next_test = 1'b1;
            TEST_REF16: next_test = ref_cnt[3];
            TEST_MCNT:  next_test = m_out;
            TEST_PAIR:  next_test = post_out;
            TEST_ZERO:  next_test = 1'b0;
            TEST_BYP:   next_test = m_out;
            TEST_PAIR4: next_test = pair_cnt[1];
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins.synth_output_pair_p <= 1'b0;
            pins.synth_output_pair_n <= 1'b1;
            pins.test_out            <= 1'b0;
        end else begin
            pins.synth_output_pair_p <= post_out;
            pins.synth_output_pair_n <= ~post_out;
            pins.test_out            <= next_test;
        end
    end

endmodule : sdpp_device
`default_nettype wire

// ===== hdl/sdpp_host.sv
// host end: axi4-lite registers that drive the parallel and serial program pins
// assumes the device samples pins with its own synchroniser on aclk
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sdpp_host
    import sdpp_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    sdpp_if.host                   pins
);
    import sdpp_pkg::*;

    typedef enum logic [1:0] {
        SDPP_IDLE   = 2'b00,
        SDPP_CLK_LO = 2'b01,
        SDPP_CLK_HI = 2'b10,
        SDPP_LOAD   = 2'b11
    } sdpp_state_t;

    // ----------------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------------
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [31:0]       w_mask;
    logic              do_write;
    logic              ctrl_pload;
    logic              start_req;
    logic [31:0]       par_reg;
    logic [31:0]       ser_reg;
    sdpp_state_t       state;

    assign s_axi_awready = ~aw_got;
    assign s_axi_wready  = ~w_got;
    assign do_write      = aw_got & w_got & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_mask       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_got) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
                w_mask <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (do_write) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr[3:2] == REG_STATUS) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable fields are kept at their documented widths
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_pload <= 1'b0;
            start_req  <= 1'b0;
            par_reg    <= '0;
            ser_reg    <= '0;
        end else begin
            start_req <= 1'b0;
            if (do_write && aw_addr[3:2] == REG_CTRL && w_mask[0]) begin
                ctrl_pload <= w_data[CTRL_PLOAD];
                // refuse a serial start unless the strobe is already high
                start_req  <= w_data[CTRL_START] & ctrl_pload;
            end
            if (do_write && aw_addr[3:2] == REG_PAR) begin
                par_reg <= ((par_reg & ~w_mask) | (w_data & w_mask)) & 32'h0000_07ff;
            end
            if (do_write && aw_addr[3:2] == REG_SER && state == SDPP_IDLE) begin
                ser_reg <= ((ser_reg & ~w_mask) | (w_data & w_mask)) & 32'h0000_3fff;
            end
        end
    end

    // ----------------------------------------------------------------
    // pin drive and serial sequencer
    // ----------------------------------------------------------------
    logic [3:0] timer;
    logic [3:0] bit_idx;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins.p_load <= 1'b0;
            pins.m_in   <= '0;
            pins.n_in   <= '0;
        end else begin
            pins.p_load <= ctrl_pload;
            pins.m_in   <= par_reg[M_MSB:0];
            pins.n_in   <= par_reg[PAR_N_LSB+1:PAR_N_LSB];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state        <= SDPP_IDLE;
            timer        <= '0;
            bit_idx      <= '0;
            pins.s_clock <= 1'b0;
            pins.s_data  <= 1'b0;
            pins.s_load  <= 1'b0;
        end else if (timer != 4'h0) begin
            timer <= timer - 4'h1;
        end else begin
            unique case (state)
                SDPP_IDLE: begin
                    if (start_req) begin
                        state       <= SDPP_CLK_LO;
                        bit_idx     <= LAST_BIT_IDX;
                        pins.s_data <= ser_reg[T_MSB];
                        timer       <= HALF_CYC - 4'h1;
                    end
                end
                SDPP_CLK_LO: begin
                    state        <= SDPP_CLK_HI;
                    pins.s_clock <= 1'b1;
                    timer        <= HALF_CYC - 4'h1;
                end
                SDPP_CLK_HI: begin
                    pins.s_clock <= 1'b0;
                    timer        <= HALF_CYC - 4'h1;
                    if (bit_idx == 4'h0) begin
                        state       <= SDPP_LOAD;
                        pins.s_load <= 1'b1;
                        timer       <= PULSE_CYC - 4'h1;
                    end else begin
                        state       <= SDPP_CLK_LO;
                        bit_idx     <= bit_idx - 4'h1;
                        pins.s_data <= ser_reg[bit_idx - 4'h1];
                    end
                end
                SDPP_LOAD: begin
                    state       <= SDPP_IDLE;
                    pins.s_load <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read with pin status
    // ----------------------------------------------------------------
    logic [2:0] obs_s1;
    logic [2:0] obs_s2;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            obs_s1 <= '0;
            obs_s2 <= '0;
        end else begin
            obs_s1 <= {pins.synth_output_pair_p, pins.test_out, 1'b0};
            obs_s2 <= obs_s1;
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr[3:2])
                REG_CTRL:   s_axi_rdata <= {31'h0, ctrl_pload};
                REG_PAR:    s_axi_rdata <= par_reg;
                REG_SER:    s_axi_rdata <= ser_reg;
                REG_STATUS: s_axi_rdata <= {29'h0, obs_s2[2:1], state != SDPP_IDLE};
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sdpp_host
`default_nettype wire

// ===== dv/sdpp_assertions.sv
// checker for the program pins and the device configuration outputs
// assumes one aclk domain, instantiated beside sdpp_if
`timescale 1ns/100ps
`default_nettype none
module sdpp_assertions (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       p_load,
    input wire logic       s_load,
    input wire logic       s_clock,
    input wire logic       s_data,
    input wire logic [8:0] m_in,
    input wire logic [1:0] n_in,
    input wire logic       synth_output_pair_p,
    input wire logic       synth_output_pair_n,
    input wire logic [8:0] fb_count,
    input wire logic [1:0] post_sel,
    input wire logic [2:0] test_sel,
    input wire logic [6:0] step_divisor,
    input wire logic       bypass
);
    // ----------------------------------------
    // reference frame, last 14 bits win
    // ----------------------------------------
    logic [13:0] shadow;
    logic        sclk_q;
    always_ff @(posedge aclk) begin
        sclk_q <= s_clock;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shadow <= 14'h0000;
        end else if (s_clock && !sclk_q && p_load) begin
            shadow <= {shadow[12:0], s_data};
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_step_ratio: assert property (
        step_divisor == (($past(post_sel) == 2'h3) ? 7'h08 : (7'h10 << $past(post_sel))))
        else $error("step divisor wrong");
    a_bypass_code: assert property (
        bypass && post_sel == 2'h3 && $past(bypass, 3) && $past(post_sel, 3) == 2'h3
        |-> synth_output_pair_p == $past(s_clock, 3)) else $error("bypass output wrong");
    a_quiet_test: assert property (
        !p_load [*5] |-> test_sel == 3'h0) else $error("test select not quiet");
    a_transparent_latch: assert property (
        (!p_load && $stable(m_in) && $stable(n_in)) [*6] |-> fb_count == m_in && post_sel == n_in)
        else $error("latch not transparent");
    a_par_capture: assert property (
        $rose(p_load) && $stable(m_in) && $stable(n_in)
        |-> ##4 fb_count == $past(m_in, 4) && post_sel == $past(n_in, 4))
        else $error("parallel capture wrong");
    a_hold_loaded: assert property (
        (p_load && !s_load) [*8] |-> $stable(fb_count) && $stable(post_sel) && $stable(test_sel))
        else $error("loaded values moved");
    a_serial_xfer: assert property (
        $fell(s_load) && p_load |-> ##4 {test_sel, post_sel, fb_count} == $past(shadow, 4))
        else $error("serial transfer wrong");
    a_pair_opposite: assert property (
        synth_output_pair_p != synth_output_pair_n) else $error("output pair not complementary");
endmodule : sdpp_assertions
`default_nettype wire

// ===== dv/tb_synth_divider_program_port.sv
// bench: axi4-lite master on the host end, device end across sdpp_if
// assumes host and device keep the hand-over timing
`timescale 1ns/100ps
`default_nettype none
module tb_synth_divider_program_port;
    import sdpp_pkg::*;
    logic        aclk, aresetn, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv, bypass;
    logic [3:0]  awa, ara, wstrb;
    logic [31:0] wd, rd;
    logic [1:0]  post_sel;
    logic [8:0]  fb_count;
    logic [2:0]  test_sel;
    logic [6:0]  step_divisor;
    logic [13:0] wire_frame;
    logic        sclk_q, sload_q;
    int          errors, checks_done, wire_bits, loads;
    sdpp_if pins ();
    sdpp_host sdpp_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .pins(pins.host));
    sdpp_device sdpp_device_inst (.aclk(aclk), .aresetn(aresetn), .pins(pins.device),
        .fb_count(fb_count), .post_sel(post_sel), .test_sel(test_sel),
        .step_divisor(step_divisor), .bypass(bypass));
    sdpp_assertions sdpp_assertions_inst (.aclk(aclk), .aresetn(aresetn),
        .p_load(pins.p_load), .s_load(pins.s_load), .s_clock(pins.s_clock),
        .s_data(pins.s_data), .m_in(pins.m_in), .n_in(pins.n_in),
        .synth_output_pair_p(pins.synth_output_pair_p),
        .synth_output_pair_n(pins.synth_output_pair_n), .fb_count(fb_count),
        .post_sel(post_sel), .test_sel(test_sel), .step_divisor(step_divisor),
        .bypass(bypass));
    always #(CLK_NS / 2) aclk = ~aclk;
    // wire view of each frame, taken at rising serial clock
    always @(posedge aclk) begin
        sclk_q <= pins.s_clock;
        sload_q <= pins.s_load;
        if (pins.s_clock && !sclk_q) begin
            wire_frame <= {wire_frame[12:0], pins.s_data};
            wire_bits <= wire_bits + 1;
        end
        if (sload_q && !pins.s_load) begin
            loads <= loads + 1;
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [6:0] exp_step(input logic [1:0] n);
        return (n == POST_DIV1) ? 7'h08 : 7'h10 << n;
    endfunction : exp_step
    // readyness is sampled mid-cycle, payload only moves after a rising edge
    task automatic axi_wr(input logic [1:0] idx, input logic [31:0] d);
        logic aw_hit, w_hit, b_hit;
        awa <= {idx, 2'h0};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        b_hit = 1'b0;
        while (!b_hit) begin
            @(negedge aclk);
            aw_hit = awv && awr;
            w_hit = wv && wr;
            b_hit = bv;
            @(posedge aclk);
            if (aw_hit) awv <= 1'b0;
            if (w_hit) wv <= 1'b0;
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [1:0] idx, output logic [31:0] d);
        logic ar_hit, r_hit;
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        r_hit = 1'b0;
        while (!r_hit) begin
            @(negedge aclk);
            ar_hit = arv && arr;
            r_hit = rv;
            d = rd;
            @(posedge aclk);
            if (ar_hit) arv <= 1'b0;
        end
    endtask : axi_rd
    task automatic chk_cfg(input logic [2:0] t, input logic [1:0] n, input logic [8:0] m);
        time t0;
        repeat (8) @(posedge aclk);
        @(negedge aclk);
        chk("fb_count", 32'(m), 32'(fb_count));
        chk("post_sel", 32'(n), 32'(post_sel));
        chk("step_divisor", 32'(exp_step(n)), 32'(step_divisor));
        chk("test_sel", 32'(t), 32'(test_sel));
        chk("bypass", 32'(t == TEST_BYP), 32'(bypass));
        // vco stand-in is aclk / 2, so the pair period is 2 * ratio cycles
        if (t != TEST_BYP) begin
            @(posedge pins.synth_output_pair_p);
            t0 = $time;
            @(posedge pins.synth_output_pair_p);
            chk("out period", 32'(exp_step(n) >> 2), 32'(($time - t0) / CLK_NS));
        end
        @(posedge aclk);
    endtask : chk_cfg
    task automatic serial_frame(input logic [13:0] f);
        int          l0, b0;
        logic [31:0] d;
        l0 = loads;
        b0 = wire_bits;
        axi_wr(REG_SER, 32'(f));
        axi_wr(REG_CTRL, 32'h3);
        for (int k = 0; k < 400 && loads == l0; k++) @(posedge aclk);
        chk("bit count", 32'(b0 + 14), 32'(wire_bits));
        chk("wire frame", 32'(f), 32'(wire_frame));
        chk_cfg(f[13:11], f[10:9], f[8:0]);
        axi_rd(REG_STATUS, d);
        chk("busy", 32'h0, {31'h0, d[0]});
    endtask : serial_frame
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #(CLK_NS * 5000);
        errors++;
        end_sim();
    end
    initial begin
        logic [8:0] m;
        logic [1:0] n;
        int         b0;
        {aclk, aresetn, awv, wv, arv, sclk_q, sload_q, awa, ara, wd} = '0;
        {brdy, rrdy, wstrb} = 6'h3f;
        {errors, checks_done, wire_bits, loads} = '0;
        wire_frame = '0;
        void'($urandom(28));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            m = 9'($urandom);
            n = 2'(i);
            axi_wr(REG_PAR, {21'h0, n, m});
            chk_cfg(TEST_QUIET, n, m);
        end
        axi_wr(REG_CTRL, 32'h1);
        axi_wr(REG_PAR, {21'h0, ~n, ~m});
        chk_cfg(TEST_QUIET, n, m);
        serial_frame({TEST_BYP, POST_DIV1, 9'h1ff});
        serial_frame({TEST_PAIR4, POST_DIV2, 9'h000});
        for (int i = 0; i < 4; i++) serial_frame(14'($urandom));
        // dropping the strobe reopens the latches and quiets the test select
        axi_wr(REG_CTRL, 32'h0);
        chk_cfg(TEST_QUIET, ~n, ~m);
        b0 = wire_bits;
        axi_wr(REG_SER, 32'h1555);
        axi_wr(REG_CTRL, 32'h2);
        repeat (80) @(posedge aclk);
        chk("refused shift", 32'(b0), 32'(wire_bits));
        chk_cfg(TEST_QUIET, ~n, ~m);
        end_sim();
    end
endmodule : tb_synth_divider_program_port
`default_nettype wire
